// ---- hdl/fosp_consts.vh ----
`ifndef FOSP_CONSTS_VH
`define FOSP_CONSTS_VH

`define FOSP_ADR_OPTION 6'h00
`define FOSP_ADR_CONFIG 6'h04
`define FOSP_ADR_PROT 6'h08
`define FOSP_ADR_STATUS 6'h0C

`define FOSP_OPT_BACKDOOR_KEY_ENABLE 7
`define FOSP_OPT_NORED 6
`define FOSP_OPT_MASK 8'hC3
`define FOSP_CFG_KEYWE 5
`define FOSP_CFG_MASK 8'h20
`define FOSP_CFG_RESET 8'h00
`define FOSP_PROT_DIS 0

`define FOSP_ST_UNSEC 0
`define FOSP_ST_VIOL 1
`define FOSP_ST_BUSY 2

`define FOSP_SEC_UNSECURED 2'h2
`define FOSP_KEY_BASE 16'hFFB0
`define FOSP_KEY_BYTES 4'h8
`define FOSP_PAGE_LOW 9'h1FF

`endif

// ---- hdl/fosp_keymem.v ----
`timescale 1ns/1ps
module fosp_keymem #(
   parameter W = 8,
   parameter AW = 3
) (
   input wire clk_i,
   input wire we_i,
   input wire [AW-1:0] waddr_i,
   input wire [W-1:0] wdata_i,
   input wire [AW-1:0] raddr_i,
   output reg [W-1:0] rdata_o
);
   reg [W-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule

// ---- hdl/fosp_top.v ----
`timescale 1ns/1ps
`include "fosp_consts.vh"
module fosp_top (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire wb_dbg_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire [7:0] nv_option_byte_i,
   input wire [7:0] nv_protection_byte_i,
   input wire [63:0] stored_backdoor_key_i,
   input wire flash_wr_i,
   input wire flash_wr_dbg_i,
   input wire [15:0] flash_addr_i,
   input wire [7:0] flash_data_i,
   input wire blank_ok_i,
   output reg cmd_start_o,
   output reg [15:0] cmd_addr_o,
   output reg [7:0] cmd_data_o,
   output reg secure_o,
   output reg dbg_mem_block_o,
   output reg vector_redirect_en_o,
   output reg protection_violation_flag_o
);
   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_CHECK = 2'h2;

   reg [7:0] option_shadow_reg_q;
   reg [7:0] flash_config_reg_q;
   reg [7:0] protection_shadow_reg_q;
   reg [1:0] security_code_q;
   reg viol_q;
   reg [3:0] key_cnt_q;
   reg key_bad_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [2:0] idx_q;
   reg [2:0] idx_d;
   reg key_hit;
   reg unsec_d;
   reg [31:0] rdata;
   reg [7:0] prot_new;
   reg prot_ok;

   wire [7:0] key_rdata;
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wb_wr = wb_req & wb_we_i & wb_sel_i[0];
   wire wr_cfg = wb_wr & (wb_adr_i == `FOSP_ADR_CONFIG);
   wire wr_prot = wb_wr & (wb_adr_i == `FOSP_ADR_PROT);
   wire wr_stat = wb_wr & (wb_adr_i == `FOSP_ADR_STATUS);
   wire key_we_en = flash_config_reg_q[`FOSP_CFG_KEYWE];
   wire prot_dis = protection_shadow_reg_q[`FOSP_PROT_DIS];
   wire [6:0] prot_sel = protection_shadow_reg_q[7:1];
   wire in_key = (flash_addr_i[15:3] == `FOSP_KEY_BASE >> 3);
   // debug key writes fall through to nothing, not to a command start
   wire key_wr = flash_wr_i & in_key & key_we_en;
   wire key_take = key_wr & ~flash_wr_dbg_i;
   wire cmd_req = flash_wr_i & ~(in_key & key_we_en);
   // protection covers everything above the end of unprotected flash
   wire is_prot = ~prot_dis & (flash_addr_i > {prot_sel, `FOSP_PAGE_LOW});
   wire [7:0] cfg_wval = wb_dat_i[7:0] & `FOSP_CFG_MASK;
   wire keywe_fall = wr_cfg & key_we_en & ~cfg_wval[`FOSP_CFG_KEYWE];
   wire cmp_go = keywe_fall & (key_cnt_q == `FOSP_KEY_BYTES) & ~key_bad_q &
      option_shadow_reg_q[`FOSP_OPT_BACKDOOR_KEY_ENABLE];

   fosp_keymem #(
      .W(8),
      .AW(3)
   ) u_keymem (
      .clk_i(clk_i),
      .we_i(key_take),
      .waddr_i(flash_addr_i[2:0]),
      .wdata_i(flash_data_i),
      .raddr_i(idx_q),
      .rdata_o(key_rdata)
   );

   // protection write acceptance
   always @* begin
      prot_new = wb_dat_i[7:0];
      prot_ok = 1'b0;
      if (wb_dbg_i | prot_dis) begin
         prot_ok = 1'b1;
      end else if (~prot_new[`FOSP_PROT_DIS] &&
                   prot_new[7:1] <= prot_sel) begin
         prot_ok = 1'b1;
      end
      // any other write would shrink the region
      if (~prot_ok) begin
         prot_new = protection_shadow_reg_q;
      end
   end

   // key comparison walks the buffered bytes in order
   always @* begin
      state_d = state_q;
      idx_d = idx_q;
      unsec_d = 1'b0;
      key_hit = (key_rdata == stored_backdoor_key_i[idx_q*8 +: 8]);
      case (state_q)
         ST_IDLE: begin
            if (cmp_go) begin
               idx_d = 3'h0;
               state_d = ST_READ;
            end
         end
         ST_READ: begin
            state_d = ST_CHECK;
         end
         ST_CHECK: begin
            if (~key_hit) begin
               state_d = ST_IDLE;
            end else if (idx_q == 3'h7) begin
               unsec_d = 1'b1;
               state_d = ST_IDLE;
            end else begin
               idx_d = idx_q + 3'h1;
               state_d = ST_READ;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @* begin
      rdata = 32'h0000_0000;
      case (wb_adr_i)
         `FOSP_ADR_OPTION: begin
            rdata[7:0] = {option_shadow_reg_q[7:2], security_code_q};
         end
         `FOSP_ADR_CONFIG: begin
            rdata[7:0] = flash_config_reg_q;
         end
         `FOSP_ADR_PROT: begin
            rdata[7:0] = protection_shadow_reg_q;
         end
         `FOSP_ADR_STATUS: begin
            rdata[`FOSP_ST_UNSEC] = (security_code_q == `FOSP_SEC_UNSECURED);
            rdata[`FOSP_ST_VIOL] = viol_q;
            rdata[`FOSP_ST_BUSY] = (state_q != ST_IDLE);
         end
         default: begin
            rdata = 32'h0000_0000;
         end
      endcase
   end

   // wishbone: one wait state, ack for one cycle, unmapped reads give zero
   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req) begin
            wb_dat_o <= rdata;
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         option_shadow_reg_q <= nv_option_byte_i & `FOSP_OPT_MASK;
         security_code_q <= nv_option_byte_i[1:0];
         protection_shadow_reg_q <= nv_protection_byte_i;
         flash_config_reg_q <= `FOSP_CFG_RESET;
      end else begin
         if (wr_cfg) begin
            flash_config_reg_q <= cfg_wval;
         end
         if (wr_prot) begin
            protection_shadow_reg_q <= prot_new;
         end
         if (unsec_d | blank_ok_i) begin
            security_code_q <= `FOSP_SEC_UNSECURED;
         end
      end
   end

   // key byte bookkeeping; bytes must arrive in address order
   always @(posedge clk_i) begin
      if (rst_i) begin
         key_cnt_q <= 4'h0;
         key_bad_q <= 1'b0;
      end else if (keywe_fall) begin
         key_cnt_q <= 4'h0;
         key_bad_q <= 1'b0;
      end else if (key_take) begin
         if (key_cnt_q == `FOSP_KEY_BYTES ||
             {1'b0, flash_addr_i[2:0]} != key_cnt_q) begin
            key_bad_q <= 1'b1;
         end else begin
            key_cnt_q <= key_cnt_q + 4'h1;
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         idx_q <= 3'h0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
      end
   end

   // violation flag: set wins over a same-cycle write-one clear
   always @(posedge clk_i) begin
      if (rst_i) begin
         viol_q <= 1'b0;
      end else if (cmd_req & is_prot) begin
         viol_q <= 1'b1;
      end else if (wr_stat & wb_dat_i[`FOSP_ST_VIOL]) begin
         viol_q <= 1'b0;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         cmd_start_o <= 1'b0;
         cmd_addr_o <= 16'h0000;
         cmd_data_o <= 8'h00;
      end else begin
         cmd_start_o <= cmd_req & ~is_prot;
         if (cmd_req) begin
            cmd_addr_o <= flash_addr_i;
            cmd_data_o <= flash_data_i;
         end
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         secure_o <= 1'b1;
         dbg_mem_block_o <= 1'b1;
         vector_redirect_en_o <= 1'b0;
         protection_violation_flag_o <= 1'b0;
      end else begin
         secure_o <= (security_code_q != `FOSP_SEC_UNSECURED);
         dbg_mem_block_o <= (security_code_q != `FOSP_SEC_UNSECURED);
         vector_redirect_en_o <= ~option_shadow_reg_q[`FOSP_OPT_NORED];
         protection_violation_flag_o <= viol_q;
      end
   end
endmodule

// ---- tb/flash_option_security_protection_test.sv ----
`timescale 1ns/1ps
module flash_option_security_protection_test;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg cyc = 1'b0, we = 1'b0, dbg = 1'b0, fwr = 1'b0, fdbg = 1'b0;
   reg blank = 1'b0;
   reg [5:0] adr = 6'h00;
   reg [3:0] sel = 4'h0;
   reg [31:0] wdat = 32'h0;
   reg [15:0] faddr = 16'h0000;
   reg [7:0] fdata = 8'h00, rd;
   wire [7:0] nvo, nvp;
   wire [63:0] key;
   wire [31:0] dat_o;
   wire [15:0] caddr;
   wire [7:0] cdata;
   wire ack, start, sec, blk, redir, viol;
   integer err_count = 0, tests_run = 0, i, n;
   always #12.5 clk_i = ~clk_i;
   fosp_nv_model u_nvm (.clk_i(clk_i), .nv_option_byte_o(nvo),
      .nv_protection_byte_o(nvp), .stored_backdoor_key_o(key));
   fosp_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dbg_i(dbg), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .nv_option_byte_i(nvo), .nv_protection_byte_i(nvp),
      .stored_backdoor_key_i(key), .flash_wr_i(fwr), .flash_wr_dbg_i(fdbg),
      .flash_addr_i(faddr), .flash_data_i(fdata), .blank_ok_i(blank),
      .cmd_start_o(start), .cmd_addr_o(caddr), .cmd_data_o(cdata),
      .secure_o(sec), .dbg_mem_block_o(blk),
      .vector_redirect_en_o(redir), .protection_violation_flag_o(viol));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         err_count = err_count + 1;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wb(input [5:0] a, input w, input [7:0] d, input from_dbg);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      sel <= 4'h1;
      wdat <= {24'h000000, d};
      dbg <= from_dbg;
      n = 0;
      @(posedge clk_i);
      while (ack !== 1'b1 && n < 20) begin
         n = n + 1;
         @(posedge clk_i);
      end
      if (n == 20) begin
         err_count = err_count + 1;
         tally_and_finish;
      end
      rd = dat_o[7:0];
      cyc <= 1'b0;
      we <= 1'b0;
   endtask
   task rdchk(input [5:0] a, input [7:0] exp);
      wb(a, 1'b0, 8'h00, 1'b0);
      chk(rd, exp);
   endtask
   // checks the start pulse in the cycle after the write is taken
   task fw(input [15:0] a, input [7:0] d, input from_dbg, input exp_start);
      @(posedge clk_i);
      fwr <= 1'b1;
      fdbg <= from_dbg;
      faddr <= a;
      fdata <= d;
      @(posedge clk_i);
      fwr <= 1'b0;
      #1;
      chk(start, exp_start);
   endtask
   task do_reset(input [7:0] opt, input [7:0] prot);
      u_nvm.reprogram(opt, prot);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
   endtask
   // compare needs 16 busy cycles plus 2 before secure falls
   task key_try(input dbg_last, input exp_sec);
      wb(6'h04, 1'b1, 8'h20, 1'b0);
      for (i = 0; i < 8; i = i + 1)
         fw(16'hFFB0 + i[15:0], key[8*i +: 8], dbg_last && i == 7, 1'b0);
      wb(6'h04, 1'b1, 8'h00, 1'b0);
      repeat (30) @(posedge clk_i);
      #1;
      chk(sec, exp_sec);
   endtask
   initial begin
      for (i = 0; i < 4; i = i + 1) begin
         do_reset(8'h3C | i[7:0], 8'hFF);
         chk(sec, i != 2);
         rdchk(6'h00, i[7:0]);
      end
      do_reset(8'hC1, 8'hFC);
      rdchk(6'h00, 8'hC1);
      chk(redir, 1'b0);
      rdchk(6'h08, 8'hFC);
      rdchk(6'h10, 8'h00);
      wb(6'h00, 1'b1, 8'h00, 1'b0);
      rdchk(6'h00, 8'hC1);
      wb(6'h08, 1'b1, 8'hFE, 1'b0);
      rdchk(6'h08, 8'hFC);
      wb(6'h08, 1'b1, 8'hF0, 1'b0);
      rdchk(6'h08, 8'hF0);
      wb(6'h08, 1'b1, 8'hFF, 1'b1);
      rdchk(6'h08, 8'hFF);
      wb(6'h08, 1'b1, 8'h00, 1'b0);
      rdchk(6'h08, 8'h00);
      fw(16'h01FF, 8'h11, 1'b0, 1'b1);
      chk(caddr, 16'h01FF);
      chk(cdata, 8'h11);
      fw(16'h0200, 8'h22, 1'b0, 1'b0);
      chk(viol, 1'b0);
      @(posedge clk_i);
      #1;
      chk(viol, 1'b1);
      rdchk(6'h0C, 8'h02);
      wb(6'h0C, 1'b1, 8'h02, 1'b0);
      rdchk(6'h0C, 8'h00);
      wb(6'h08, 1'b1, 8'h01, 1'b1);
      fw(16'hFFB0, 8'h33, 1'b0, 1'b1);
      key_try(1'b1, 1'b1);
      key_try(1'b0, 1'b0);
      chk(blk, 1'b0);
      rdchk(6'h00, 8'hC2);
      do_reset(8'h01, 8'hFF);
      chk(redir, 1'b1);
      key_try(1'b0, 1'b1);
      @(posedge clk_i);
      blank <= 1'b1;
      @(posedge clk_i);
      blank <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      chk(sec, 1'b0);
      tally_and_finish;
   end
endmodule

// ---- tb/fosp_checker.sv ----
`timescale 1ns/1ps
module fosp_checker (
   input wire clk_i,
   input wire rst_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire flash_wr_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   input wire cmd_start_o,
   input wire secure_o,
   input wire dbg_mem_block_o,
   input wire vector_redirect_en_o,
   input wire protection_violation_flag_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire req = wb_cyc_i && wb_stb_i;
   wire viol = protection_violation_flag_o;
   a_ack_follows: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack wider than one cycle");
   a_rd_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 0)
      else $error("upper read bits set");
   a_debug_blocked: assert property (dbg_mem_block_o == secure_o)
      else $error("debug block differs from secure");
   a_secure_sticky: assert property (!secure_o |=> !secure_o)
      else $error("secure returned without reset");
   a_redirect_fixed: assert property (
      !$past(rst_i) && !$past(rst_i, 2) && !$past(rst_i, 3)
      |-> $stable(vector_redirect_en_o)) else $error("redirect moved");
   a_cmd_cause: assert property (cmd_start_o |-> $past(flash_wr_i))
      else $error("start without flash write");
   a_viol_cause: assert property ($rose(viol) |-> $past(flash_wr_i, 2))
      else $error("violation without flash write");
   a_viol_hold: assert property (viol && !(req && wb_we_i) |=> viol)
      else $error("violation dropped without clear");
   cover property (cmd_start_o);
   cover property ($fell(secure_o));
   cover property ($rose(viol));
endmodule
bind fosp_top fosp_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .flash_wr_i, .wb_dat_o, .wb_ack_o, .cmd_start_o, .secure_o,
   .dbg_mem_block_o, .vector_redirect_en_o, .protection_violation_flag_o);

// ---- tb/fosp_nv_model.sv ----
`timescale 1ns/1ps
module fosp_nv_model #(
   parameter [63:0] KEY = 64'h8877665544332211
) (
   input wire clk_i,
   output reg [7:0] nv_option_byte_o,
   output reg [7:0] nv_protection_byte_o,
   output wire [63:0] stored_backdoor_key_o
);
   // bytes only move when reprogrammed; the device sees them at next reset
   assign stored_backdoor_key_o = KEY;
   initial nv_option_byte_o = 8'h00;
   initial nv_protection_byte_o = 8'hFF;
   task reprogram(input [7:0] opt, input [7:0] prot);
      @(posedge clk_i);
      nv_option_byte_o <= opt;
      nv_protection_byte_o <= prot;
   endtask
endmodule
